// File: common/hpr_pkg.sv
// Constants shared by the host port register interface
package hpr_pkg;
  // ----------------------------------------------------------------
  // Function select codes {select_a, select_b}
  // ----------------------------------------------------------------
  localparam logic [1:0] HPR_SEL_PTR_LOW = 2'h0;
  localparam logic [1:0] HPR_SEL_PTR_HIGH = 2'h1;
  localparam logic [1:0] HPR_SEL_DATA = 2'h2;
  localparam logic [1:0] HPR_SEL_CONTROL = 2'h3;
  // ----------------------------------------------------------------
  // Control word field positions
  // ----------------------------------------------------------------
  localparam int HPR_BIT_HALT = 15;
  localparam int HPR_BIT_CACHE_FLUSH = 14;
  localparam int HPR_BIT_LOWER_BYTE_LAST = 13;
  localparam int HPR_BIT_INC_READ = 12;
  localparam int HPR_BIT_INC_WRITE = 11;
  localparam int HPR_BIT_NMI_SAVE = 9;
  localparam int HPR_BIT_NMI = 8;
  localparam int HPR_BIT_INT_TO_HOST = 7;
  localparam int HPR_MSG_OUT_HI = 6;
  localparam int HPR_MSG_OUT_LO = 4;
  localparam int HPR_BIT_INT_FROM_HOST = 3;
  localparam int HPR_MSG_IN_HI = 2;
  localparam int HPR_MSG_IN_LO = 0;
  // Host-writable named control bits other than the special ones
  localparam logic [15:0] HPR_CTL_HOST_MASK = 16'hfa07;
  // ----------------------------------------------------------------
  // Reset values and pointer layout
  // ----------------------------------------------------------------
  localparam logic [15:0] HPR_RESET_WORD = 16'h0000;
  localparam logic [31:0] HPR_PTR_STEP = 32'h0000_0010;
  localparam logic [31:0] HPR_PTR_FORCE_MASK = 32'hffff_fff0;
endpackage

// File: src/hpr_host_port.sv
// Host port register interface: pointer, data and control registers
`timescale 1ns/1ps
// Contract
// - Provide sixteen bit host port
// - Four sixteen bit host registers
// - Chip select, selects and strobes decode
// - Pointer pair forms 32-bit address
// - Low holds bits 15:0, high 31:16
// - Pointer low four bits forced zero
// - Byte access: low then high byte
// - Data register carries word both ways
// - Control is two control bytes joined
// - Lower byte last picks triggering byte
// - Increment before read, after write
// - NMI bit pulses, clears when taken
// - Interrupt out: processor sets, host clears
//
// Usage notes for whoever integrates this port:
// - The host strobes are level signals taken as synchronous to clk.
//   Each access acts once, on the first edge where it decodes true,
//   so the host must return both strobes high between accesses.
// - Byte lanes are chosen by host_byte_high; an 8-bit host writes a
//   register as two byte accesses, a 16-bit host may read the word.
// - A local bus cycle starts on the trigger byte only. With
//   lower_byte_last clear that is the upper byte, so an 8-bit host
//   writes low then high; with it set the order is the reverse.
// - While a memory write is still pending, a new trigger starts no new cycle,
//   but a host data write or read increment still changes the queued write's data or address.
// - The low four pointer bits never reach the memory side: they are
//   masked on the address and on host reads of the low word, so the
//   pointer always names a whole word.
//
module hpr_host_port
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_chip_select_n,
  input wire logic function_select_a,
  input wire logic function_select_b,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_byte_high,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_n,
  output logic host_interrupt_pin_n,
  output logic [31:0] mem_address,
  output logic mem_read_request,
  output logic mem_write_request,
  output logic [15:0] mem_write_data,
  input wire logic mem_done,
  input wire logic [15:0] mem_read_data,
  input wire logic cpu_ctl_write,
  input wire logic [15:0] cpu_ctl_data,
  input wire logic nmi_taken,
  output logic halt,
  output logic cache_flush,
  output logic nonmaskable_save_select,
  output logic nmi_request,
  output logic interrupt_from_host
);
  import hpr_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The four host-visible words live in plain flops; nothing here is
  // large enough to need an array.
  logic [15:0] ptr_low_reg;
  logic [15:0] ptr_high_reg;
  logic [15:0] data_reg;
  logic [15:0] control_reg;
  logic access_reg;
  logic mem_read_reg;
  logic mem_write_reg;
  logic [1:0] sel;
  logic strobe_active;
  logic rd_access;
  logic wr_access;
  logic rd_start;
  logic wr_start;
  logic trigger_byte;
  logic [31:0] ptr_full;
  logic [31:0] ptr_inc;
  logic [15:0] read_word;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Merge one byte lane, chosen by high, into a register value
  function automatic logic [15:0] merge_byte(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic high);
    merge_byte = high ? {new_val[15:8], old_val[7:0]} : {old_val[15:8], new_val[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // chip select decode
  assign sel = {function_select_a, function_select_b};
  assign rd_access = !host_chip_select_n && !host_read_strobe_n && host_write_strobe_n;
  assign wr_access = !host_chip_select_n && host_read_strobe_n && !host_write_strobe_n;
  assign strobe_active = rd_access || wr_access;
  // Act once per strobe: edge taken from a registered copy
  assign rd_start = rd_access && !access_reg;
  assign wr_start = wr_access && !access_reg;
  assign trigger_byte = control_reg[HPR_BIT_LOWER_BYTE_LAST] ? 1'b0 : 1'b1;

  assign ptr_full = {ptr_high_reg, ptr_low_reg} & HPR_PTR_FORCE_MASK;
  assign ptr_inc = ptr_full + HPR_PTR_STEP;
  assign mem_address = ptr_full;
  assign mem_read_request = mem_read_reg;
  assign mem_write_request = mem_write_reg;
  assign mem_write_data = data_reg;

  // Strobe history for single action per access
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      access_reg <= 1'b0;
    else
      access_reg <= strobe_active;
  end

  // ----------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------
  // byte-wise pointer writes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr_low_reg <= HPR_RESET_WORD;
      ptr_high_reg <= HPR_RESET_WORD;
    end
    else if (wr_start && sel == HPR_SEL_PTR_LOW)
      ptr_low_reg <= merge_byte(ptr_low_reg, host_data_in, host_byte_high);
    else if (wr_start && sel == HPR_SEL_PTR_HIGH)
      ptr_high_reg <= merge_byte(ptr_high_reg, host_data_in, host_byte_high);
    else if (rd_start && sel == HPR_SEL_DATA && host_byte_high == trigger_byte
             && control_reg[HPR_BIT_INC_READ])
      {ptr_high_reg, ptr_low_reg} <= ptr_inc;
    else if (mem_write_reg && mem_done && control_reg[HPR_BIT_INC_WRITE])
      {ptr_high_reg, ptr_low_reg} <= ptr_inc;
  end

  // ----------------------------------------------------------------
  // Local bus cycle requests
  // ----------------------------------------------------------------
  // cycle start on chosen byte
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_read_reg <= 1'b0;
      mem_write_reg <= 1'b0;
    end
    else
    begin
      if (mem_done)
      begin
        mem_read_reg <= 1'b0;
        mem_write_reg <= 1'b0;
      end
      // Pointer high write prefetches; data read fetches the next word with inc read set, else the same word again
      if (host_byte_high == trigger_byte && !mem_write_reg)
      begin
        if ((wr_start && sel == HPR_SEL_PTR_HIGH) || (rd_start && sel == HPR_SEL_DATA))
          mem_read_reg <= 1'b1;
        else if (wr_start && sel == HPR_SEL_DATA)
          mem_write_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data transfer register
  // ----------------------------------------------------------------
  // word both directions
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      data_reg <= HPR_RESET_WORD;
    else if (wr_start && sel == HPR_SEL_DATA)
      data_reg <= merge_byte(data_reg, host_data_in, host_byte_high);
    else if (mem_read_reg && mem_done)
      data_reg <= mem_read_data;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // two control bytes joined
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control_reg <= HPR_RESET_WORD;
    else
    begin
      if (wr_start && sel == HPR_SEL_CONTROL)
      begin
        if (host_byte_high)
        begin
          control_reg[15:9] <= host_data_in[15:9];
          if (host_data_in[HPR_BIT_NMI])
            control_reg[HPR_BIT_NMI] <= 1'b1;
        end
        else
        begin
          control_reg[HPR_MSG_IN_HI:HPR_MSG_IN_LO] <= host_data_in[HPR_MSG_IN_HI:HPR_MSG_IN_LO];
          if (!host_data_in[HPR_BIT_INT_TO_HOST])
            control_reg[HPR_BIT_INT_TO_HOST] <= 1'b0;
          // Host raises its request; only the processor drops it
          if (host_data_in[HPR_BIT_INT_FROM_HOST])
            control_reg[HPR_BIT_INT_FROM_HOST] <= 1'b1;
        end
      end
      else if (cpu_ctl_write)
      begin
        control_reg[15:9] <= cpu_ctl_data[15:9];
        control_reg[HPR_MSG_OUT_HI:HPR_MSG_OUT_LO] <= cpu_ctl_data[HPR_MSG_OUT_HI:HPR_MSG_OUT_LO];
        if (cpu_ctl_data[HPR_BIT_INT_TO_HOST])
          control_reg[HPR_BIT_INT_TO_HOST] <= 1'b1;
        if (!cpu_ctl_data[HPR_BIT_INT_FROM_HOST])
          control_reg[HPR_BIT_INT_FROM_HOST] <= 1'b0;
      end
      // processor set survives a host write in the same cycle
      // The set must win: a lost set would swallow a host interrupt.
      if (cpu_ctl_write && cpu_ctl_data[HPR_BIT_INT_TO_HOST])
        control_reg[HPR_BIT_INT_TO_HOST] <= 1'b1;
      if (nmi_taken && !(wr_start && sel == HPR_SEL_CONTROL && host_byte_high
                         && host_data_in[HPR_BIT_NMI]))
        control_reg[HPR_BIT_NMI] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  // register select for reads
  always_comb
  begin
    unique case (sel)
      HPR_SEL_PTR_LOW: read_word = ptr_low_reg & HPR_PTR_FORCE_MASK[15:0];
      HPR_SEL_PTR_HIGH: read_word = ptr_high_reg;
      HPR_SEL_DATA: read_word = data_reg;
      HPR_SEL_CONTROL: read_word = control_reg;
    endcase
  end

  // The read word is refreshed on every edge of a read, so a slow
  // host that holds its strobe sees the latest register contents.
  // registered sixteen bit output
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      host_data_out <= HPR_RESET_WORD;
    else if (rd_access)
      host_data_out <= read_word;
  end

  // Bus driven only during reads; enable is active low
  assign host_data_oe_n = !rd_access;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Straight taps of the control word; the processor side samples
  // them on its own clock edge, so no extra flop stage is added.
  // interrupt pin active low
  assign host_interrupt_pin_n = !control_reg[HPR_BIT_INT_TO_HOST];
  assign halt = control_reg[HPR_BIT_HALT];
  assign cache_flush = control_reg[HPR_BIT_CACHE_FLUSH];
  assign nonmaskable_save_select = control_reg[HPR_BIT_NMI_SAVE];
  assign nmi_request = control_reg[HPR_BIT_NMI];
  assign interrupt_from_host = control_reg[HPR_BIT_INT_FROM_HOST];
endmodule

// File: test/hpr_host_port_asserts.sv
// Port checker for the host port register interface
`timescale 1ns/1ps
module hpr_host_port_asserts import hpr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_chip_select_n,
  input wire logic function_select_a,
  input wire logic function_select_b,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_byte_high,
  input wire logic [15:0] host_data_in,
  input wire logic host_data_oe_n,
  input wire logic host_interrupt_pin_n,
  input wire logic [31:0] mem_address,
  input wire logic mem_write_request,
  input wire logic [15:0] mem_write_data,
  input wire logic mem_done,
  input wire logic cpu_ctl_write,
  input wire logic [15:0] cpu_ctl_data,
  input wire logic nmi_taken,
  input wire logic halt,
  input wire logic nmi_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic wa, ra;
  logic [1:0] s;
  // Access decode; cs high guards keep a same-edge host write out of the way
  assign s = {function_select_a, function_select_b};
  assign wa = !host_chip_select_n && host_read_strobe_n && !host_write_strobe_n;
  assign ra = !host_chip_select_n && !host_read_strobe_n && host_write_strobe_n;
  property p_low; mem_address[3:0] == 4'h0; endproperty
  a_low: assert property (p_low) else $error("pointer nibble set");
  property p_oe; ra |-> !host_data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("read not driven");
  property p_pin; cpu_ctl_write && cpu_ctl_data[7] && host_chip_select_n |=> !host_interrupt_pin_n; endproperty
  a_pin: assert property (p_pin) else $error("host interrupt not low");
  property p_nmi; nmi_taken && host_chip_select_n |=> !nmi_request; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not cleared");
  property p_hold; mem_write_request && !mem_done |=> mem_write_request; endproperty
  a_hold: assert property (p_hold) else $error("write request dropped");
  property p_drop; mem_done && mem_write_request && host_chip_select_n |=> !mem_write_request; endproperty
  a_drop: assert property (p_drop) else $error("write request stuck");
  property p_wd; $rose(wa && s == HPR_SEL_DATA && !host_byte_high) && !mem_write_request
    |=> mem_write_data[7:0] == $past(host_data_in[7:0]); endproperty
  a_wd: assert property (p_wd) else $error("low data byte lost");
  property p_halt; $rose(wa && s == HPR_SEL_CONTROL && host_byte_high)
    |=> halt == $past(host_data_in[15]); endproperty
  a_halt: assert property (p_halt) else $error("control high byte lost");
endmodule
bind hpr_host_port hpr_host_port_asserts u_chk (.*);

// File: test/hpr_mem_model.sv
// Local memory stand-in answering the port's read and write requests
`timescale 1ns/1ps
module hpr_mem_model
(
  input wire logic clk,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] lat,
  output logic done,
  output logic [15:0] rdata
);
  logic [15:0] mem [logic [31:0]];
  int n = 0;
  initial {done, rdata} = 17'h0;
  // word at the pointer; read data churns so stale words never match
  always @(posedge clk)
  begin
    done <= (rd_req || wr_req) && !done && n == lat;
    n <= (rd_req || wr_req) && !done ? n + 1 : 0;
    rdata <= ~rdata;
    if ((rd_req || wr_req) && !done && n == lat)
    begin
      if (wr_req) mem[addr] = wdata;
      else rdata <= mem.exists(addr) ? mem[addr] : addr[19:4];
    end
  end
endmodule

// File: test/hpr_host_port_tb_top.sv
// Self-checking bench for the host port register interface
`timescale 1ns/1ps
module hpr_host_port_tb_top;
  logic clk, reset_n, host_chip_select_n, function_select_a, function_select_b, halt;
  logic host_read_strobe_n, host_write_strobe_n, host_byte_high, host_data_oe_n, mem_done;
  logic host_interrupt_pin_n, mem_read_request, mem_write_request, cpu_ctl_write, nmi_taken;
  logic cache_flush, nonmaskable_save_select, nmi_request, interrupt_from_host;
  logic [15:0] host_data_in, host_data_out, mem_write_data, mem_read_data, cpu_ctl_data, w;
  logic [31:0] mem_address, pa;
  logic [3:0] lat;
  int seed = 70265;
  int fail_count = 0;
  int tests_run = 0;
  hpr_host_port dut (.*);
  hpr_mem_model mem (.clk(clk), .rd_req(mem_read_request), .wr_req(mem_write_request),
    .addr(mem_address), .wdata(mem_write_data), .lat(lat), .done(mem_done),
    .rdata(mem_read_data));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobed byte access, then an idle cycle so the next one is seen as new
  task acc(input logic [1:0] s, input logic we, input logic hi, input logic [7:0] d);
    {function_select_a, function_select_b} = s;
    host_byte_high = hi;
    host_data_in = {d, d};
    {host_chip_select_n, host_read_strobe_n, host_write_strobe_n} = {1'b0, we, !we};
    @(negedge clk);
    {host_chip_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
    @(negedge clk);
  endtask
  task wr16(input logic [1:0] s, input logic [15:0] v);
    acc(s, 1'b1, 1'b0, v[7:0]);
    acc(s, 1'b1, 1'b1, v[15:8]);
  endtask
  task mwait;
    for (int i = 0; i < 40 && (mem_read_request || mem_write_request); i++) @(negedge clk);
    chk(mem_read_request || mem_write_request, 32'h0);
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard at 2000 cycles, well past the under one hundred cycles the sequence needs
  initial
  begin
    #50000;
    fail_count++;
    end_of_test;
  end
  initial
  begin
    {host_chip_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
    {function_select_a, function_select_b, host_byte_high, cpu_ctl_write, nmi_taken} = 5'h0;
    host_data_in = 16'h0;
    cpu_ctl_data = 16'h0080;
    lat = 4'h0;
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      acc(s[1:0], 1'b0, 1'b0, 8'h0);
      chk(host_data_out, 32'h0);
    end
    chk(host_interrupt_pin_n, 32'h1);
    pa = $random(seed);
    wr16(2'h0, pa[15:0]);
    wr16(2'h1, pa[31:16]);
    pa[3:0] = 4'h0;
    chk(mem_address, pa);
    mwait;
    acc(2'h0, 1'b0, 1'b0, 8'h0);
    chk(host_data_out, pa[15:0]);
    acc(2'h1, 1'b0, 1'b0, 8'h0);
    chk(host_data_out, pa[31:16]);
    acc(2'h2, 1'b0, 1'b0, 8'h0);
    chk(host_data_out, pa[19:4]);
    acc(2'h3, 1'b1, 1'b1, 8'h08);
    w = $random(seed);
    wr16(2'h2, w);
    chk(mem_write_data, w);
    mwait;
    chk(mem_address, pa + 32'h10);
    acc(2'h3, 1'b1, 1'b1, 8'h00);
    lat = 4'h5;
    wr16(2'h0, pa[15:0]);
    wr16(2'h1, pa[31:16]);
    mwait;
    acc(2'h2, 1'b0, 1'b0, 8'h0);
    chk(host_data_out, w);
    acc(2'h3, 1'b1, 1'b1, 8'h20);
    acc(2'h2, 1'b1, 1'b1, w[15:8]);
    chk(mem_write_request, 32'h0);
    acc(2'h2, 1'b1, 1'b0, w[7:0]);
    chk(mem_write_request, 32'h1);
    mwait;
    acc(2'h3, 1'b1, 1'b1, 8'h81);
    chk(halt, 32'h1);
    chk(nmi_request, 32'h1);
    nmi_taken = 1'b1;
    @(negedge clk);
    nmi_taken = 1'b0;
    chk(nmi_request, 32'h0);
    cpu_ctl_write = 1'b1;
    @(negedge clk);
    cpu_ctl_write = 1'b0;
    chk(host_interrupt_pin_n, 32'h0);
    acc(2'h3, 1'b1, 1'b0, 8'h80);
    chk(host_interrupt_pin_n, 32'h0);
    acc(2'h3, 1'b1, 1'b0, 8'h00);
    chk(host_interrupt_pin_n, 32'h1);
    end_of_test;
  end
endmodule
